// ==== core/psi_pkg.sv ====
// Purpose: shared constants and types of the power stage generator input stage
// Assumes: 8-bit register port, 100 MHz generator clock
// Notes: register offsets are word indices on the plain register port
package psi_pkg;

    // register map
    localparam logic [1:0] ADDR_CTRL_A = 2'h0;
    localparam logic [1:0] ADDR_CTRL_B = 2'h1;
    localparam logic [1:0] ADDR_MISC = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;

    // misc register fields
    localparam int MISC_KILL_A_BIT = 0;
    localparam int MISC_KILL_B_BIT = 1;
    localparam int MISC_RELEASE_BIT = 2;

    // status register fields
    localparam int STAT_ACT_A_BIT = 0;
    localparam int STAT_ACT_B_BIT = 1;
    localparam int STAT_BUSY_A_BIT = 2;
    localparam int STAT_BUSY_B_BIT = 3;
    localparam int STAT_HALT_BIT = 4;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] KILL_RESET = 2'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // digital noise filter length in generator clock cycles
    localparam int FILTER_CYCLES = 4;

    // running mode codes from the counter core
    localparam logic [1:0] RUN_ONE_RAMP = 2'h0;
    localparam logic [1:0] RUN_TWO_RAMP = 2'h1;
    localparam logic [1:0] RUN_FOUR_RAMP = 2'h2;
    localparam logic [1:0] RUN_CENTERED = 2'h3;

    // input mode field codes
    localparam logic [3:0] MODE_NONE = 4'h0;
    localparam logic [3:0] MODE_1 = 4'h1;
    localparam logic [3:0] MODE_2 = 4'h2;
    localparam logic [3:0] MODE_3 = 4'h3;
    localparam logic [3:0] MODE_4 = 4'h4;
    localparam logic [3:0] MODE_5 = 4'h5;
    localparam logic [3:0] MODE_6 = 4'h6;
    localparam logic [3:0] MODE_7 = 4'h7;
    localparam logic [3:0] MODE_8 = 4'h8;
    localparam logic [3:0] MODE_9 = 4'h9;
    localparam logic [3:0] MODE_14 = 4'hE;

    // per-half control register layout
    typedef struct packed {
        logic src_cmp;
        logic filt_en;
        logic edge_sel;
        logic lvl_hi;
        logic [3:0] mode;
    } psi_half_cfg_t;

    // one-hot sub-cycle phase of the counter core
    typedef struct packed {
        logic ot1;
        logic dt1;
        logic ot0;
        logic dt0;
    } psi_phase_t;

    // requests to the counter and dead-time core
    typedef struct packed {
        logic halt;
        logic clear_cnt;
        logic jump_b;
        logic jump_a;
        logic hold_b;
        logic hold_a;
        logic off_b;
        logic off_a;
    } psi_req_t;

    localparam psi_req_t REQ_RESET = 8'h00;

    // per-half sequencing states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_HOLD = 7'h02,
        ST_OPP = 7'h04,
        ST_WAIT = 7'h08,
        ST_BURST = 7'h10,
        ST_HALT = 7'h20,
        ST_MASK = 7'h40
    } psi_state_t;

endpackage

// ==== core/psi_input_stage.sv ====
// Purpose: retrigger and fault input stage for both halves of the generator
// Assumes: counter core supplies phase, half-end and ramp-start pulses on clk
// Notes: async_kill is the one combinational output, it must work clockless
`timescale 1ns/1ns
`default_nettype none

module psi_input_stage (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] fault_retrigger_pin,
    input wire logic [1:0] comparator_result,
    input wire logic [1:0] running_mode,
    input wire psi_pkg::psi_phase_t phase,
    input wire logic [1:0] half_end,
    input wire logic ramp_start,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output psi_pkg::psi_req_t core_req,
    output logic [1:0] async_kill
);

    // window of a half: A lives in dt0/ot0, B in dt1/ot1
    function automatic logic half_window(input logic hsel, input psi_pkg::psi_phase_t p);
        half_window = hsel ? (p.dt1 | p.ot1) : (p.dt0 | p.ot0);
    endfunction

    logic [7:0] ctrl_reg [2];
    logic [1:0] kill_reg;
    logic [7:0] rdata_reg;
    psi_pkg::psi_req_t req_reg;
    psi_pkg::psi_req_t req_next;
    psi_pkg::psi_state_t st_reg [2];
    psi_pkg::psi_state_t st_next [2];
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [psi_pkg::FILTER_CYCLES-2:0] hist_reg [2];
    logic [1:0] filt_reg;
    logic [1:0] act_prev_reg;

    psi_pkg::psi_half_cfg_t cfg [2];
    wire logic [1:0] sel_in;
    wire logic [1:0] filt_same;
    wire logic [1:0] sig;
    wire logic [1:0] act;
    wire logic [1:0] ev;
    wire logic [1:0] win;
    wire logic [1:0] own_ot;
    wire logic centered;
    wire logic one_ramp;
    wire logic wr_misc;
    wire logic release_halt;
    wire logic [7:0] status_word;
    wire logic [7:0] rd_mux;
    logic [1:0] off;
    logic [1:0] hold;
    logic [1:0] jump;
    logic [1:0] clr;
    logic [1:0] halt;
    logic mode4_any;

    assign cfg[0] = psi_pkg::psi_half_cfg_t'(ctrl_reg[0]);
    assign cfg[1] = psi_pkg::psi_half_cfg_t'(ctrl_reg[1]);
    assign centered = (running_mode == psi_pkg::RUN_CENTERED);
    assign one_ramp = (running_mode == psi_pkg::RUN_ONE_RAMP);

    // per-half input conditioning and window
    for (genvar h = 0; h < 2; h++) begin : g_half
        // select after the synchroniser, so a source switch never feeds a raw pin to logic
        assign sel_in[h] = cfg[h].src_cmp ? sync2_reg[2+h] : sync2_reg[h];
        assign filt_same[h] = (hist_reg[h] == {(psi_pkg::FILTER_CYCLES-1){sel_in[h]}});
        assign sig[h] = cfg[h].filt_en ? filt_reg[h] : sel_in[h];
        assign act[h] = cfg[h].lvl_hi ? sig[h] : ~sig[h];
        // edge or level acting per half
        assign ev[h] = cfg[h].edge_sel ? (act[h] & ~act_prev_reg[h]) : act[h];
        // centered: never; one ramp: always; else own half only
        assign win[h] = ~centered & (one_ramp | half_window(h == 1, phase));
        assign own_ot[h] = h ? phase.ot1 : phase.ot0;
    end

    // direct kill path, no clock involved, pin polarity from level select
    assign async_kill[0] = kill_reg[0] & ~(fault_retrigger_pin[0] ^ cfg[0].lvl_hi);
    assign async_kill[1] = kill_reg[1] & ~(fault_retrigger_pin[1] ^ cfg[1].lvl_hi);

    // register port decode
    assign wr_misc = reg_wr & (reg_addr == psi_pkg::ADDR_MISC);
    assign release_halt = wr_misc & reg_wdata[psi_pkg::MISC_RELEASE_BIT];
    assign status_word = {3'h0, (st_reg[0] == psi_pkg::ST_HALT) | (st_reg[1] == psi_pkg::ST_HALT),
                          st_reg[1] != psi_pkg::ST_IDLE, st_reg[0] != psi_pkg::ST_IDLE, act[1], act[0]};
    assign rd_mux = (reg_addr == psi_pkg::ADDR_CTRL_A) ? ctrl_reg[0] :
                    (reg_addr == psi_pkg::ADDR_CTRL_B) ? ctrl_reg[1] :
                    (reg_addr == psi_pkg::ADDR_MISC) ? {6'h00, kill_reg} : status_word;

    // per-half sequencer; mode decode on the four-bit field
    always_comb begin
        mode4_any = 1'b0;
        for (int h = 0; h < 2; h++) begin
            st_next[h] = st_reg[h];
            off[h] = 1'b0;
            hold[h] = 1'b0;
            jump[h] = 1'b0;
            clr[h] = 1'b0;
            halt[h] = 1'b0;
            if (cfg[h].mode == psi_pkg::MODE_4 && act[h]) begin
                mode4_any = 1'b1;
            end
            if (cfg[h].mode == psi_pkg::MODE_14 && act[h]) begin
                off[h] = 1'b1;
            end
            unique case (st_reg[h])
                psi_pkg::ST_IDLE: begin
                    if (ev[h] && win[h]) begin
                        // zero and reserved codes fall to no action
                        case (cfg[h].mode)
                            psi_pkg::MODE_1: begin
                                if (one_ramp) begin
                                    clr[h] = 1'b1;
                                end else begin
                                    st_next[h] = psi_pkg::ST_HOLD;
                                end
                            end
                            psi_pkg::MODE_2: begin
                                if (one_ramp) begin
                                    clr[h] = 1'b1;
                                end else begin
                                    jump[h] = 1'b1;
                                    st_next[h] = psi_pkg::ST_OPP;
                                end
                            end
                            psi_pkg::MODE_3: begin
                                if (one_ramp) begin
                                    clr[h] = 1'b1;
                                end else begin
                                    jump[h] = 1'b1;
                                    st_next[h] = psi_pkg::ST_BURST;
                                end
                            end
                            psi_pkg::MODE_5, psi_pkg::MODE_6, psi_pkg::MODE_8: begin
                                clr[h] = one_ramp;
                                jump[h] = ~one_ramp;
                            end
                            psi_pkg::MODE_7: st_next[h] = psi_pkg::ST_HALT;
                            psi_pkg::MODE_9: st_next[h] = psi_pkg::ST_MASK;
                            default: st_next[h] = psi_pkg::ST_IDLE;
                        endcase
                    end
                end
                psi_pkg::ST_HOLD: begin
                    // stall, then run the opposite half once released
                    hold[h] = act[h];
                    if (!act[h]) begin
                        jump[h] = 1'b1;
                        st_next[h] = psi_pkg::ST_IDLE;
                    end
                end
                psi_pkg::ST_OPP: begin
                    // opposite half always completes, release or not
                    if (half_end[1-h]) begin
                        st_next[h] = psi_pkg::ST_WAIT;
                    end
                end
                psi_pkg::ST_WAIT: begin
                    hold[h] = act[h];
                    if (!act[h]) begin
                        st_next[h] = psi_pkg::ST_IDLE;
                    end
                end
                psi_pkg::ST_BURST: begin
                    // skip own on-time while active, leave only outside opposite half
                    if (act[h] && own_ot[h]) begin
                        jump[h] = 1'b1;
                    end else if (!act[h] && !half_window(~h[0], phase)) begin
                        st_next[h] = psi_pkg::ST_IDLE;
                    end
                end
                psi_pkg::ST_HALT: begin
                    halt[h] = ~release_halt;
                    if (release_halt) begin
                        st_next[h] = psi_pkg::ST_IDLE;
                    end
                end
                psi_pkg::ST_MASK: begin
                    // frequency untouched, output back on the next ramp
                    if (ramp_start) begin
                        st_next[h] = psi_pkg::ST_IDLE;
                    end
                end
                default: st_next[h] = psi_pkg::ST_IDLE;
            endcase
            if (st_next[h] inside {psi_pkg::ST_HOLD, psi_pkg::ST_OPP, psi_pkg::ST_WAIT,
                                   psi_pkg::ST_BURST, psi_pkg::ST_MASK}) begin
                off[h] = 1'b1;
            end
        end
        req_next.off_a = off[0] | mode4_any;
        req_next.off_b = off[1] | mode4_any;
        req_next.hold_a = hold[0];
        req_next.hold_b = hold[1];
        req_next.jump_a = jump[0];
        req_next.jump_b = jump[1];
        req_next.clear_cnt = clr[0] | clr[1];
        req_next.halt = halt[0] | halt[1] | (st_next[0] == psi_pkg::ST_HALT) | (st_next[1] == psi_pkg::ST_HALT);
    end

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {comparator_result, fault_retrigger_pin};
            sync2_reg <= sync1_reg;
        end
    end

    // filter history: output follows only after four equal samples
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hist_reg[0] <= '0;
            hist_reg[1] <= '0;
            filt_reg <= 2'h0;
            act_prev_reg <= 2'h0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                hist_reg[h] <= {hist_reg[h][psi_pkg::FILTER_CYCLES-3:0], sel_in[h]};
                if (filt_same[h]) begin
                    filt_reg[h] <= sel_in[h];
                end
            end
            act_prev_reg <= act;
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg[0] <= psi_pkg::CTRL_RESET;
            ctrl_reg[1] <= psi_pkg::CTRL_RESET;
            kill_reg <= psi_pkg::KILL_RESET;
        end else begin
            if (reg_wr && reg_addr == psi_pkg::ADDR_CTRL_A) begin
                ctrl_reg[0] <= reg_wdata;
            end
            if (reg_wr && reg_addr == psi_pkg::ADDR_CTRL_B) begin
                ctrl_reg[1] <= reg_wdata;
            end
            if (wr_misc) begin
                kill_reg <= {reg_wdata[psi_pkg::MISC_KILL_B_BIT], reg_wdata[psi_pkg::MISC_KILL_A_BIT]};
            end
        end
    end

    // state, requests and read data; read data valid only the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg[0] <= psi_pkg::ST_IDLE;
            st_reg[1] <= psi_pkg::ST_IDLE;
            req_reg <= psi_pkg::REQ_RESET;
            rdata_reg <= psi_pkg::RDATA_RESET;
        end else begin
            st_reg[0] <= st_next[0];
            st_reg[1] <= st_next[1];
            req_reg <= req_next;
            rdata_reg <= reg_rd ? rd_mux : psi_pkg::RDATA_RESET;
        end
    end

    assign core_req = req_reg;
    assign reg_rdata = rdata_reg;

    // checks
    property p_centered_quiet;
        @(posedge clk) disable iff (!nrst)
        (centered && st_reg[0] == psi_pkg::ST_IDLE && st_reg[1] == psi_pkg::ST_IDLE)
            |=> !core_req.jump_a && !core_req.jump_b && !core_req.clear_cnt;
    endproperty
    a_centered_quiet: assert property (p_centered_quiet) else $error("retrigger acted in centered mode");

    property p_jump_two_ramp;
        @(posedge clk) disable iff (!nrst)
        (running_mode == psi_pkg::RUN_TWO_RAMP && cfg[0].mode == psi_pkg::MODE_8
            && st_reg[0] == psi_pkg::ST_IDLE && ev[0] && (phase.dt0 || phase.ot0)) |=> core_req.jump_a;
    endproperty
    a_jump_two_ramp: assert property (p_jump_two_ramp) else $error("retrigger did not end half A");

    property p_clear_one_ramp;
        @(posedge clk) disable iff (!nrst)
        (one_ramp && cfg[1].mode == psi_pkg::MODE_8 && st_reg[1] == psi_pkg::ST_IDLE && ev[1])
            |=> core_req.clear_cnt && !core_req.jump_b;
    endproperty
    a_clear_one_ramp: assert property (p_clear_one_ramp) else $error("one ramp retrigger did not clear");

    property p_window_b;
        @(posedge clk) disable iff (!nrst)
        (running_mode == psi_pkg::RUN_FOUR_RAMP && st_reg[1] == psi_pkg::ST_IDLE
            && !phase.dt1 && !phase.ot1) |=> !core_req.jump_b;
    endproperty
    a_window_b: assert property (p_window_b) else $error("input B acted outside its half");

    property p_mode1_hold;
        @(posedge clk) disable iff (!nrst)
        (st_reg[0] == psi_pkg::ST_HOLD && act[0]) |=> core_req.off_a && core_req.hold_a && !core_req.jump_a;
    endproperty
    a_mode1_hold: assert property (p_mode1_hold) else $error("mode 1 hold not kept");

    property p_mode4_off;
        @(posedge clk) disable iff (!nrst)
        (cfg[0].mode == psi_pkg::MODE_4 && act[0]) |=> core_req.off_a && core_req.off_b && !core_req.jump_a;
    endproperty
    a_mode4_off: assert property (p_mode4_off) else $error("mode 4 did not force outputs off");

    property p_halt_sticks;
        @(posedge clk) disable iff (!nrst)
        (st_reg[0] == psi_pkg::ST_HALT && !release_halt) |=> core_req.halt && st_reg[0] == psi_pkg::ST_HALT;
    endproperty
    a_halt_sticks: assert property (p_halt_sticks) else $error("halt dropped without software");

    property p_filter_blocks;
        @(posedge clk) disable iff (!nrst)
        (sel_in[0] != hist_reg[0][0]) |=> $stable(filt_reg[0]);
    endproperty
    a_filter_blocks: assert property (p_filter_blocks) else $error("filter passed a short pulse");

    property p_async_kill;
        @(posedge clk) disable iff (!nrst)
        (kill_reg[1] && (fault_retrigger_pin[1] == cfg[1].lvl_hi)) |-> async_kill[1];
    endproperty
    a_async_kill: assert property (p_async_kill) else $error("async kill not asserted");

    property p_mode14_off;
        @(posedge clk) disable iff (!nrst)
        (cfg[1].mode == psi_pkg::MODE_14 && act[1]) ##1 act[1] |-> core_req.off_b;
    endproperty
    a_mode14_off: assert property (p_mode14_off) else $error("mode 14 output not off");

    property p_mask_until_ramp;
        @(posedge clk) disable iff (!nrst)
        (st_reg[0] == psi_pkg::ST_MASK && !ramp_start) |=> core_req.off_a && st_reg[0] == psi_pkg::ST_MASK;
    endproperty
    a_mask_until_ramp: assert property (p_mask_until_ramp) else $error("mode 9 mask ended early");

endmodule

`default_nettype wire

// ==== testbench/psi_far_side.sv ====
// Purpose: far-side model of the fault pins and the comparator outputs
// Assumes: the bench commands each level, the model launches it after an edge
// Notes: lines carry no pull, so they always show a commanded level
`timescale 1ns/1ns
`default_nettype none

module psi_far_side (
    input wire logic clk,
    input wire logic [1:0] pin_cmd,
    input wire logic [1:0] cmp_cmd,
    output logic [1:0] pin_out,
    output logic [1:0] cmp_out
);
    // launched just after the same clk edge the design samples on; the design still passes it through its synchroniser
    always @(posedge clk) begin
        pin_out <= pin_cmd;
        cmp_out <= cmp_cmd;
    end
endmodule
`default_nettype wire

// ==== testbench/test_psi_input_stage.sv ====
// Purpose: self-checking bench of the input stage
// Assumes: counter core is played by the bench through phase and running mode
// Notes: only legal mode codes are programmed
`timescale 1ns/1ns
`default_nettype none

module test_psi_input_stage;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] pin_cmd = 2'h0;
    logic [1:0] cmp_cmd = 2'h0;
    wire logic [1:0] pin_w;
    wire logic [1:0] cmp_w;
    logic [1:0] running_mode = psi_pkg::RUN_TWO_RAMP;
    psi_pkg::psi_phase_t phase = 4'h1;
    logic [1:0] half_end = 2'h0;
    logic ramp_start = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic [7:0] reg_rdata;
    psi_pkg::psi_req_t core_req;
    wire logic [1:0] async_kill;
    wire logic [7:0] req_bits = core_req;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int n0;
    int n1;
    logic [7:0] rv;

    psi_far_side i_psi_far_side (.clk(clk), .pin_cmd(pin_cmd), .cmp_cmd(cmp_cmd), .pin_out(pin_w), .cmp_out(cmp_w));

    // the bench plays the counter core, its half-end and ramp-start pulses included
    psi_input_stage i_psi_input_stage (.clk(clk), .nrst(nrst), .fault_retrigger_pin(pin_w),
        .comparator_result(cmp_w), .running_mode(running_mode), .phase(phase), .half_end(half_end),
        .ramp_start(ramp_start), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req), .async_kill(async_kill));

    // free-running clock
    initial begin
        forever #5 clk = ~clk;
    end

    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic drive(input int h, input logic v, input logic cmp);
        @(posedge clk);
        if (cmp) cmp_cmd[h] <= v;
        else pin_cmd[h] <= v;
    endtask

    task automatic wait_bit(input int b, input int lim, output int n);
        n = 0;
        while (req_bits[b] !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // idle input, configure, then one transition to the active level
    task automatic trial(input int h, input logic [7:0] cfg, input logic [1:0] rm, input logic [3:0] ph,
        input int b, output int n);
        @(posedge clk);
        running_mode <= rm;
        phase <= ph;
        drive(h, ~cfg[4], cfg[7]);
        wr(2'(h), cfg);
        repeat (8) @(posedge clk);
        drive(h, cfg[4], cfg[7]);
        wait_bit(b, 20, n);
        drive(h, ~cfg[4], cfg[7]);
        repeat (12) @(posedge clk);
        wr(2'(h), 8'h00);
    endtask

    task automatic t_regs();
        rd(psi_pkg::ADDR_CTRL_A, rv);
        chk(rv, psi_pkg::CTRL_RESET);
        rd(psi_pkg::ADDR_MISC, rv);
        chk(rv, 8'h00);
        wr(psi_pkg::ADDR_STATUS, 8'hFF);
        rd(psi_pkg::ADDR_STATUS, rv);
        chk(rv, 8'h03);
        wr(psi_pkg::ADDR_CTRL_B, 8'hDE);
        rd(psi_pkg::ADDR_CTRL_B, rv);
        chk(rv, 8'hDE);
        wr(psi_pkg::ADDR_CTRL_B, 8'h00);
        wr(psi_pkg::ADDR_MISC, 8'h07);
        rd(psi_pkg::ADDR_MISC, rv);
        chk(rv, 8'h03);
        wr(psi_pkg::ADDR_MISC, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_retrig();
        trial(0, 8'h38, psi_pkg::RUN_TWO_RAMP, 4'h1, 4, n0);
        chk({7'h00, n0 < 20}, 8'h01);
        trial(0, 8'h38, psi_pkg::RUN_CENTERED, 4'h1, 4, n1);
        chk({7'h00, n1 < 20}, 8'h00);
        trial(0, 8'h38, psi_pkg::RUN_TWO_RAMP, 4'h4, 4, n1);
        chk({7'h00, n1 < 20}, 8'h00);
        trial(1, 8'h38, psi_pkg::RUN_FOUR_RAMP, 4'h4, 5, n1);
        chk({7'h00, n1 < 20}, 8'h01);
        trial(0, 8'h38, psi_pkg::RUN_ONE_RAMP, 4'h4, 6, n1);
        chk({7'h00, n1 < 20}, 8'h01);
        trial(0, 8'hB8, psi_pkg::RUN_TWO_RAMP, 4'h1, 4, n1);
        chk({7'h00, n1 < 20}, 8'h01);
        trial(0, 8'h28, psi_pkg::RUN_TWO_RAMP, 4'h1, 4, n1);
        chk({7'h00, n1 < 20}, 8'h01);
        trial(0, 8'h30, psi_pkg::RUN_TWO_RAMP, 4'h1, 4, n1);
        chk({7'h00, n1 < 20}, 8'h00);
        trial(0, 8'h78, psi_pkg::RUN_TWO_RAMP, 4'h1, 4, n1);
        chk(8'(n1 - n0), 8'(psi_pkg::FILTER_CYCLES));
        $display("test retrigger done");
    endtask

    // level mode 4 with the clockless kill armed on half A
    task automatic t_mode4();
        @(posedge clk);
        running_mode <= psi_pkg::RUN_CENTERED;
        wr(psi_pkg::ADDR_CTRL_A, 8'h14); // level-acting mode 4, both outputs forced off while active
        wr(psi_pkg::ADDR_MISC, 8'h01);
        drive(0, 1'b1, 1'b0);
        @(posedge clk);
        #1 chk({6'h00, async_kill}, 8'h01);
        wait_bit(0, 20, n1);
        repeat (5) @(posedge clk);
        #1 chk(req_bits, 8'h03);
        drive(0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        #1 chk({6'h00, async_kill}, 8'h00);
        chk(req_bits, 8'h00);
        wr(psi_pkg::ADDR_MISC, 8'h00);
        wr(psi_pkg::ADDR_CTRL_A, 8'h00);
        $display("test mode4 done");
    endtask

    task automatic t_mode1();
        @(posedge clk);
        running_mode <= psi_pkg::RUN_TWO_RAMP;
        phase <= 4'h2;
        wr(psi_pkg::ADDR_CTRL_A, 8'h11);
        drive(0, 1'b1, 1'b0);
        wait_bit(2, 20, n1);
        repeat (4) @(posedge clk);
        #1 chk(req_bits, 8'h05);
        drive(0, 1'b0, 1'b0);
        wait_bit(4, 20, n1);
        chk({7'h00, n1 < 20}, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk(req_bits, 8'h00);
        wr(psi_pkg::ADDR_CTRL_A, 8'h00);
        $display("test mode1 done");
    endtask

    task automatic t_halt();
        @(posedge clk);
        running_mode <= psi_pkg::RUN_ONE_RAMP;
        wr(psi_pkg::ADDR_CTRL_A, 8'h37);
        drive(0, 1'b1, 1'b0);
        wait_bit(7, 20, n1);
        drive(0, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        #1 chk({7'h00, req_bits[7]}, 8'h01);
        rd(psi_pkg::ADDR_STATUS, rv);
        chk(rv & 8'h10, 8'h10);
        wr(psi_pkg::ADDR_MISC, 8'h04);
        repeat (3) @(posedge clk);
        #1 chk({7'h00, req_bits[7]}, 8'h00);
        wr(psi_pkg::ADDR_CTRL_A, 8'h00);
        $display("test halt done");
    endtask

    // mode 2 then mode 3 on half A in two ramp; the bench ends half B by hand
    task automatic t_mode2_3();
        @(posedge clk);
        running_mode <= psi_pkg::RUN_TWO_RAMP;
        phase <= 4'h2;
        wr(psi_pkg::ADDR_CTRL_A, 8'h12);
        drive(0, 1'b1, 1'b0);
        wait_bit(4, 20, n1);
        chk({7'h00, n1 < 20}, 8'h01);
        repeat (4) @(posedge clk);
        #1 chk(req_bits, 8'h01);
        @(posedge clk);
        half_end <= 2'h2;
        @(posedge clk);
        half_end <= 2'h0;
        repeat (3) @(posedge clk);
        #1 chk(req_bits, 8'h05);
        drive(0, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        #1 chk(req_bits, 8'h00);
        wr(psi_pkg::ADDR_CTRL_A, 8'h13);
        drive(0, 1'b1, 1'b0);
        wait_bit(4, 20, n1);
        repeat (2) @(posedge clk);
        #1 chk(req_bits, 8'h11);
        @(posedge clk);
        phase <= 4'h1;
        repeat (3) @(posedge clk);
        #1 chk(req_bits, 8'h01);
        drive(0, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        #1 chk(req_bits, 8'h00);
        wr(psi_pkg::ADDR_CTRL_A, 8'h00);
        $display("test mode2 mode3 done");
    endtask

    // mode 9 on half A in one ramp, mode 14 on half B in two ramp
    task automatic t_mode9_14();
        @(posedge clk);
        running_mode <= psi_pkg::RUN_ONE_RAMP;
        wr(psi_pkg::ADDR_CTRL_A, 8'h39);
        drive(0, 1'b1, 1'b0);
        wait_bit(0, 20, n1);
        repeat (4) @(posedge clk);
        #1 chk(req_bits, 8'h01);
        @(posedge clk);
        ramp_start <= 1'b1;
        @(posedge clk);
        ramp_start <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(req_bits, 8'h00);
        drive(0, 1'b0, 1'b0);
        wr(psi_pkg::ADDR_CTRL_A, 8'h00);
        @(posedge clk);
        running_mode <= psi_pkg::RUN_TWO_RAMP;
        wr(psi_pkg::ADDR_CTRL_B, 8'h1E);
        drive(1, 1'b1, 1'b0);
        wait_bit(1, 20, n1);
        repeat (3) @(posedge clk);
        #1 chk(req_bits, 8'h02);
        drive(1, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        #1 chk(req_bits, 8'h00);
        wr(psi_pkg::ADDR_CTRL_B, 8'h00);
        $display("test mode9 mode14 done");
    endtask

    // reset held 16 cycles, then every scenario in turn
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_retrig();
        t_mode4();
        t_mode1();
        t_halt();
        t_mode2_3();
        t_mode9_14();
        tally_and_finish();
    end
endmodule
`default_nettype wire
